/* File: include/dpa_pkg.sv */
// Constants and types for the dual pointer address unit
package dpa_pkg;
    localparam int PTR_W = 16;
    localparam int BYTE_W = 8;
    localparam logic [15:0] REGION_A_BASE = 16'h0000;
    localparam logic [15:0] REGION_B_BASE = 16'h0100;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] STEP_ONE = 16'h0001;
    // Signal processing config bit positions
    localparam int SPC_REDIRECT = 0;
    localparam int SPC_IDX_DIS = 1;
    localparam int SPC_WIN_LO = 2;
    localparam int SPC_WIN_HI = 3;
    localparam int SPC_CIRC0 = 4;
    localparam int SPC_CIRC1 = 5;
    // Pointer config bit positions
    localparam int PCF_DEC0 = 0;
    localparam int PCF_DEC1 = 1;
    localparam int PCF_UPD0 = 2;
    localparam int PCF_UPD1 = 3;
    localparam logic [7:0] SPC_RESET = 8'h00;
    localparam logic [7:0] PCF_RESET = 8'h00;
    // Core operations presented to the unit
    typedef enum logic [2:0] {
        DPA_OP_NONE = 3'b000,
        DPA_OP_INC = 3'b001,
        DPA_OP_XDATA = 3'b010,
        DPA_OP_CODE = 3'b011,
        DPA_OP_CODE_IDX = 3'b100
    } dpa_op_t;
    typedef enum logic [1:0] {
        DPA_WR_NONE = 2'b00,
        DPA_WR_LOW = 2'b01,
        DPA_WR_HIGH = 2'b10
    } dpa_wr_t;
endpackage

/* File: rtl/dpa_step.sv */
// Next pointer value with circular wrap
`timescale 1ns/1ps
module dpa_step
    import dpa_pkg::*;
#(
    parameter int W = PTR_W
)(
    input wire logic [W-1:0] ptr,
    input wire logic [7:0] depth,
    input wire logic circ_en,
    input wire logic dec,
    output logic [W-1:0] next_ptr
);
    wire [W-1:0] top_a = {{(W-8){1'b0}}, depth};
    wire [W-1:0] top_b = REGION_B_BASE + top_a;
    wire in_a = (ptr <= top_a);
    wire in_b = (ptr >= REGION_B_BASE) && (ptr <= top_b);
    wire wrap_on = circ_en && (in_a || in_b);
    wire [W-1:0] plain = dec ? ptr - STEP_ONE : ptr + STEP_ONE;
    wire up_wrap_a = !dec && (ptr == top_a);
    wire up_wrap_b = !dec && (ptr == top_b);
    wire dn_wrap_a = dec && (ptr == REGION_A_BASE);
    wire dn_wrap_b = dec && (ptr == REGION_B_BASE);
    assign next_ptr = !wrap_on ? plain :
        up_wrap_a ? REGION_A_BASE :
        up_wrap_b ? REGION_B_BASE :
        dn_wrap_a ? top_a :
        dn_wrap_b ? top_b : plain;
endmodule // dpa_step

/* File: rtl/dpa_unit.sv */
// Dual data pointer address generation unit
`timescale 1ns/1ps
// Contract
// - Two 16-bit pointers, byte-wise read/write
// - Per-pointer circular enable bits
// - Two equal regions sized by depth
// - Regions at 0000 and 0100 plus depth
// - Either pointer uses either region
// - Wrap only when enabled and inside region
// - Increment at top wraps to base
// - Decrement at base wraps to top
// - Wrap applies to increment and auto-update
// - Outside regions ordinary 16-bit arithmetic
// - Decrement bit reverses increment instruction
// - Auto-update after external and code moves
// - Auto-update direction from decrement bit
// - Redirect pointer one moves to secondary
// - Index disable drops accumulator add
// - Window select picks accumulator segment
module dpa_unit
    import dpa_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [2:0] op,
    input wire logic pointer_select,
    input wire logic [7:0] accumulator,
    input wire logic wr_zero,
    input wire logic wr_one,
    input wire logic [1:0] wr_byte,
    input wire logic [7:0] wr_data,
    input wire logic depth_wr,
    input wire logic [7:0] depth_data,
    input wire logic spc_wr,
    input wire logic [7:0] spc_data,
    input wire logic pcf_wr,
    input wire logic [7:0] pcf_data,
    output logic [15:0] mem_addr,
    output logic use_secondary,
    output logic [1:0] accumulator_window_select,
    output logic [7:0] pointer_zero_low_byte,
    output logic [7:0] pointer_zero_high_byte,
    output logic [7:0] pointer_one_low_byte,
    output logic [7:0] pointer_one_high_byte,
    output logic [7:0] buffer_depth,
    output logic [7:0] signal_processing_config,
    output logic [7:0] pointer_config
);
    // ****************************************
    // Decode
    // ****************************************
    logic [15:0] pointer_zero;
    logic [15:0] pointer_one;
    wire dpa_op_t cur_op = dpa_op_t'(op);
    wire is_inc = (cur_op == DPA_OP_INC);
    wire is_move = (cur_op == DPA_OP_XDATA) || (cur_op == DPA_OP_CODE)
        || (cur_op == DPA_OP_CODE_IDX);
    wire circular_enable_zero = signal_processing_config[SPC_CIRC0];
    wire circular_enable_one = signal_processing_config[SPC_CIRC1];
    wire redirect_to_secondary_operand =
        signal_processing_config[SPC_REDIRECT];
    wire index_disable = signal_processing_config[SPC_IDX_DIS];
    wire decrement_select_zero = pointer_config[PCF_DEC0];
    wire decrement_select_one = pointer_config[PCF_DEC1];
    wire auto_update_zero = pointer_config[PCF_UPD0];
    wire auto_update_one = pointer_config[PCF_UPD1];
    wire [15:0] sel_ptr = pointer_select ? pointer_one : pointer_zero;
    wire sel_upd = pointer_select ? auto_update_one : auto_update_zero;
    // Step fires on increment instruction or auto-updated move
    wire step_req = is_inc || (is_move && sel_upd);
    wire step_zero = step_req && !pointer_select;
    wire step_one = step_req && pointer_select;
    wire [15:0] next_zero;
    wire [15:0] next_one;
    // Indexed code read adds accumulator unless disabled
    wire [15:0] idx_addr = sel_ptr + {8'h00, accumulator};
    wire [15:0] next_mem_addr = (cur_op == DPA_OP_CODE_IDX && !index_disable)
        ? idx_addr : sel_ptr;
    wire next_use_secondary = is_move && pointer_select
        && redirect_to_secondary_operand;
    wire wr_lo = (wr_byte == DPA_WR_LOW);
    wire wr_hi = (wr_byte == DPA_WR_HIGH);
    wire [7:0] next_signal_processing_config = spc_wr ? spc_data
        : signal_processing_config;
    wire [1:0] next_window =
        next_signal_processing_config[SPC_WIN_HI:SPC_WIN_LO];

    // ****************************************
    // Pointer steppers
    // ****************************************
    // Any pointer may use either region
    dpa_step #(.W(PTR_W)) u_step_zero (
        .ptr(pointer_zero),
        .depth(buffer_depth),
        .circ_en(circular_enable_zero),
        .dec(decrement_select_zero),
        .next_ptr(next_zero)
    );
    dpa_step #(.W(PTR_W)) u_step_one (
        .ptr(pointer_one),
        .depth(buffer_depth),
        .circ_en(circular_enable_one),
        .dec(decrement_select_one),
        .next_ptr(next_one)
    );
    wire [15:0] next_pointer_zero = (wr_zero && wr_lo)
        ? {pointer_zero[15:8], wr_data}
        : (wr_zero && wr_hi) ? {wr_data, pointer_zero[7:0]}
        : step_zero ? next_zero : pointer_zero;
    wire [15:0] next_pointer_one = (wr_one && wr_lo)
        ? {pointer_one[15:8], wr_data}
        : (wr_one && wr_hi) ? {wr_data, pointer_one[7:0]}
        : step_one ? next_one : pointer_one;

    // ****************************************
    // State
    // ****************************************
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pointer_zero <= PTR_RESET;
            pointer_one <= PTR_RESET;
            buffer_depth <= BYTE_RESET;
            signal_processing_config <= SPC_RESET;
            pointer_config <= PCF_RESET;
        end
        else
        begin
            pointer_zero <= next_pointer_zero;
            pointer_one <= next_pointer_one;
            if (depth_wr)
                buffer_depth <= depth_data;
            if (spc_wr)
                signal_processing_config <= spc_data;
            if (pcf_wr)
                pointer_config <= pcf_data;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            mem_addr <= PTR_RESET;
            use_secondary <= 1'b0;
            accumulator_window_select <= 2'b00;
            pointer_zero_low_byte <= BYTE_RESET;
            pointer_zero_high_byte <= BYTE_RESET;
            pointer_one_low_byte <= BYTE_RESET;
            pointer_one_high_byte <= BYTE_RESET;
        end
        else
        begin
            mem_addr <= next_mem_addr;
            use_secondary <= next_use_secondary;
            accumulator_window_select <= next_window;
            pointer_zero_low_byte <= next_pointer_zero[7:0];
            pointer_zero_high_byte <= next_pointer_zero[15:8];
            pointer_one_low_byte <= next_pointer_one[7:0];
            pointer_one_high_byte <= next_pointer_one[15:8];
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_inc_wrap_a:
    assert property (@(posedge clk) disable iff (!reset_n)
        (is_inc && !pointer_select && circular_enable_zero
         && !decrement_select_zero && pointer_zero == {8'h00, buffer_depth}
         && !wr_zero) |=> pointer_zero == REGION_A_BASE)
    else $error("pointer zero failed to wrap to region base");
    a_dec_wrap_b:
    assert property (@(posedge clk) disable iff (!reset_n)
        (is_inc && pointer_select && circular_enable_one
         && decrement_select_one && pointer_one == REGION_B_BASE
         && !wr_one)
        |=> pointer_one == REGION_B_BASE + {8'h00, $past(buffer_depth)})
    else $error("pointer one failed to wrap to region top");
    a_plain_step:
    assert property (@(posedge clk) disable iff (!reset_n)
        (is_inc && !pointer_select && !decrement_select_zero && !wr_zero
         && pointer_zero > REGION_B_BASE + {8'h00, buffer_depth})
        |=> pointer_zero == $past(pointer_zero) + STEP_ONE)
    else $error("pointer zero not stepped plainly");
    a_no_update:
    assert property (@(posedge clk) disable iff (!reset_n)
        (is_move && !pointer_select && !auto_update_zero && !wr_zero)
        |=> $stable(pointer_zero))
    else $error("pointer zero moved without auto update");
    a_redirect_out:
    assert property (@(posedge clk) disable iff (!reset_n)
        (op inside {DPA_OP_XDATA, DPA_OP_CODE, DPA_OP_CODE_IDX}
         && pointer_select && signal_processing_config[SPC_REDIRECT])
        |=> use_secondary)
    else $error("secondary operand not selected");
    a_redirect_off:
    assert property (@(posedge clk) disable iff (!reset_n)
        !pointer_select |=> !use_secondary)
    else $error("secondary operand used for pointer zero");
    a_index_off:
    assert property (@(posedge clk) disable iff (!reset_n)
        (cur_op == DPA_OP_CODE_IDX && index_disable)
        |=> mem_addr == $past(sel_ptr))
    else $error("index not disabled");
    a_bytes_match:
    assert property (@(posedge clk) disable iff (!reset_n)
        ##1 {pointer_one_high_byte, pointer_one_low_byte} == pointer_one)
    else $error("pointer one bytes disagree");
    a_window_sel:
    assert property (@(posedge clk) disable iff (!reset_n)
        spc_wr |=> accumulator_window_select
            == $past(spc_data[SPC_WIN_HI:SPC_WIN_LO]))
    else $error("window select not updated");
    a_low_write:
    assert property (@(posedge clk) disable iff (!reset_n)
        (wr_one && wr_byte == DPA_WR_LOW)
        |=> pointer_one_low_byte == $past(wr_data))
    else $error("pointer one low byte not written");
endmodule // dpa_unit

/* File: tb/dpa_core_model.sv */
// Core side model issuing pointer operations and writes
`timescale 1ns/1ps
module dpa_core_model
    import dpa_pkg::*;
(
    input wire logic clk,
    output logic [2:0] op,
    output logic pointer_select,
    output logic [7:0] accumulator,
    output logic wr_zero,
    output logic wr_one,
    output logic [1:0] wr_byte,
    output logic [7:0] wr_data,
    output logic depth_wr,
    output logic spc_wr,
    output logic pcf_wr,
    output logic [7:0] cfg_data
);
    // ****************
    // Core requests
    // ****************
    initial
    begin
        {op, pointer_select, accumulator, wr_zero, wr_one} = '0;
        {wr_byte, wr_data, depth_wr, spc_wr, pcf_wr, cfg_data} = '0;
    end
    task automatic set_ptr(input logic s, input logic [15:0] v);
        @(posedge clk);
        wr_zero <= !s;
        wr_one <= s;
        wr_byte <= DPA_WR_LOW;
        wr_data <= v[7:0];
        @(posedge clk);
        wr_byte <= DPA_WR_HIGH;
        wr_data <= v[15:8];
        @(posedge clk);
        {wr_zero, wr_one, wr_byte} <= '0;
    endtask
    task automatic cfg(input int k, input logic [7:0] d);
        @(posedge clk);
        depth_wr <= (k == 0);
        spc_wr <= (k == 1);
        pcf_wr <= (k == 2);
        cfg_data <= d;
        @(posedge clk);
        {depth_wr, spc_wr, pcf_wr} <= '0;
    endtask
    task automatic run(input dpa_op_t o, input logic s, input logic [7:0] a);
        @(posedge clk);
        op <= o;
        pointer_select <= s;
        accumulator <= a;
        @(posedge clk);
        op <= DPA_OP_NONE;
    endtask
endmodule // dpa_core_model

/* File: tb/tb_dpa_unit.sv */
// Self-checking bench for the dual pointer address unit
`timescale 1ns/1ps
module tb_dpa_unit
    import dpa_pkg::*;
;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [2:0] op;
    logic ps, wz, wo, dw, sw, pw, sec;
    logic [1:0] wb, win;
    logic [7:0] acc, wd, cd, p0l, p0h, p1l, p1h, dep, spc, pcf;
    logic [15:0] addr;
    int err_total = 0;
    int checked = 0;
    initial
    begin
        forever #10 clk = ~clk;
    end
    dpa_core_model core_u (.clk(clk), .op(op), .pointer_select(ps),
        .accumulator(acc), .wr_zero(wz), .wr_one(wo), .wr_byte(wb),
        .wr_data(wd), .depth_wr(dw), .spc_wr(sw), .pcf_wr(pw),
        .cfg_data(cd));
    dpa_unit dut_u (.clk(clk), .reset_n(reset_n), .op(op),
        .pointer_select(ps), .accumulator(acc), .wr_zero(wz),
        .wr_one(wo), .wr_byte(wb), .wr_data(wd), .depth_wr(dw),
        .depth_data(cd), .spc_wr(sw), .spc_data(cd), .pcf_wr(pw),
        .pcf_data(cd), .mem_addr(addr), .use_secondary(sec),
        .accumulator_window_select(win), .pointer_zero_low_byte(p0l),
        .pointer_zero_high_byte(p0h), .pointer_one_low_byte(p1l),
        .pointer_one_high_byte(p1h), .buffer_depth(dep),
        .signal_processing_config(spc), .pointer_config(pcf));
    // ****************
    // Checks
    // ****************
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            err_total++;
            $display("Error %0s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic go(dpa_op_t o, logic s, logic [7:0] a,
        logic [15:0] p, logic [15:0] ea, logic [15:0] ep);
        core_u.set_ptr(s, p);
        core_u.run(o, s, a);
        #1;
        if (o != DPA_OP_INC)
        begin
            chk("mem_addr", ea, addr);
        end
        chk("pointer", ep, s ? {p1h, p1l} : {p0h, p0l});
    endtask
    task automatic stop_test();
        $display("Checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial
    begin
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("reset", 16'h0, {p0h, p0l} | {p1h, p1l} | {dep, spc} | addr
            | {pcf, 5'h0, sec, win});
        core_u.set_ptr(1'b1, 16'h5aa5);
        #1;
        chk("pointer_one", 16'h5aa5, {p1h, p1l});
        core_u.cfg(0, 8'h07);
        core_u.cfg(1, 8'h30);
        #1;
        chk("depth_spc", 16'h0730, {dep, spc});
        go(DPA_OP_INC, 1'b0, 8'h0, 16'h0007, 16'h0, 16'h0000);
        go(DPA_OP_INC, 1'b1, 8'h0, 16'h0107, 16'h0, 16'h0100);
        go(DPA_OP_INC, 1'b0, 8'h0, 16'h0108, 16'h0, 16'h0109);
        go(DPA_OP_INC, 1'b1, 8'h0, 16'h00ff, 16'h0, 16'h0100);
        core_u.cfg(2, 8'h03);
        #1;
        chk("pointer_config", 16'h0003, {8'h00, pcf});
        go(DPA_OP_INC, 1'b0, 8'h0, 16'h0000, 16'h0, 16'h0007);
        go(DPA_OP_INC, 1'b1, 8'h0, 16'h0100, 16'h0, 16'h0107);
        go(DPA_OP_INC, 1'b0, 8'h0, 16'h0050, 16'h0, 16'h004f);
        core_u.cfg(2, 8'h00);
        core_u.cfg(1, 8'h20);
        go(DPA_OP_INC, 1'b0, 8'h0, 16'h0007, 16'h0, 16'h0008);
        go(DPA_OP_INC, 1'b1, 8'h0, 16'h0107, 16'h0, 16'h0100);
        $display("Test circular wrap done");
        core_u.cfg(1, 8'h30);
        core_u.cfg(2, 8'h0c);
        go(DPA_OP_XDATA, 1'b0, 8'h0, 16'h0007, 16'h0007, 16'h0);
        go(DPA_OP_CODE, 1'b1, 8'h0, 16'h0050, 16'h0050, 16'h51);
        core_u.cfg(2, 8'h0e);
        go(DPA_OP_CODE, 1'b1, 8'h0, 16'h0100, 16'h100, 16'h107);
        core_u.cfg(2, 8'h00);
        go(DPA_OP_XDATA, 1'b0, 8'h0, 16'h0007, 16'h07, 16'h07);
        $display("Test auto update done");
        core_u.cfg(1, 8'h00);
        go(DPA_OP_CODE_IDX, 1'b0, 8'h10, 16'h20, 16'h30, 16'h20);
        core_u.cfg(1, 8'h02);
        go(DPA_OP_CODE_IDX, 1'b0, 8'h10, 16'h20, 16'h20, 16'h20);
        core_u.cfg(1, 8'h01);
        go(DPA_OP_XDATA, 1'b1, 8'h0, 16'h0300, 16'h300, 16'h300);
        chk("use_secondary", 16'h1, {15'h0, sec});
        go(DPA_OP_XDATA, 1'b0, 8'h0, 16'h0300, 16'h300, 16'h300);
        chk("use_secondary", 16'h0, {15'h0, sec});
        for (int w = 0; w < 4; w++)
        begin
            core_u.cfg(1, 8'(w << 2));
            #1;
            chk("window", 16'(w), {14'h0, win});
        end
        $display("Test moves and window done");
        // Reset with non-zero pointers and settings
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("mid_reset", 16'h0, {p0h, p0l} | {p1h, p1l} | {dep, spc} | addr
            | {pcf, 5'h0, sec, win});
        $display("Test mid-run reset done");
        stop_test();
    end
endmodule // tb_dpa_unit
